// ===== fec_consts.vh
// Constants for the flash erase, cache profiling and block guard controller.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef FEC_CONSTS_VH
`define FEC_CONSTS_VH
// Register byte offsets on the APB bus.
`define FEC_OFS_READY 12'h400
`define FEC_OFS_MODE 12'h504
`define FEC_OFS_PAGE_A 12'h508
`define FEC_OFS_ERASE_ALL 12'h50c
`define FEC_OFS_PAGE_B 12'h510
`define FEC_OFS_USER_ERASE 12'h514
`define FEC_OFS_CACHE_SETUP 12'h540
`define FEC_OFS_HIT_COUNT 12'h548
`define FEC_OFS_MISS_COUNT 12'h54c
`define FEC_OFS_PROT0 12'h600
`define FEC_OFS_PROT1 12'h604
`define FEC_OFS_DBG_BYPASS 12'h608
`define FEC_OFS_PROT2 12'h610
`define FEC_OFS_PROT3 12'h614
// Field positions.
`define FEC_BIT_CACHE_ON 0
`define FEC_BIT_PROFILING_ON 8
`define FEC_BIT_CMD 0
`define FEC_BIT_BYPASS 0
// Mode field values held in the configuration register.
`define FEC_MODE_READ 2'h0
`define FEC_MODE_WRITE 2'h1
`define FEC_MODE_ERASE 2'h2
// Reset value of every register.
`define FEC_RESET_WORD 32'h00000000
// Least operation times: word program in ns, erases in us.
`define FEC_T_WORD_NS 67500
`define FEC_T_PAGE_US 2050
`define FEC_T_ALL_US 6720
`define FEC_CLK_NS 50
// Block guard: 4 kB blocks, address bits above this index select the block.
`define FEC_BLOCK_SHIFT 12
`endif

// ===== fec_busy_timer.v
// Busy timer for program and erase operations of the flash controller.
// Assumes one clock domain; the start pulse carries the length in cycles.
`timescale 1ns/1ns
module fec_busy_timer #(
  parameter CW = 24
) (
  // Clock, reset and enable.
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // Start request with its length.
  input wire start,
  input wire [CW-1:0] cycles,
  // Status.
  output wire busy,
  output reg done
);
  // Remaining cycles of the running operation.
  reg [CW-1:0] left_ff;
  assign busy = (left_ff != {CW{1'b0}});

  // Load on start, count down, pulse done on the last cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_ff <= {CW{1'b0}};
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (start && !busy) begin
        left_ff <= cycles;
      end else if (busy) begin
        left_ff <= left_ff - {{(CW-1){1'b0}}, 1'b1};
        // The final decrement marks completion.
        if (left_ff == {{(CW-1){1'b0}}, 1'b1}) begin
          done <= 1'b1;
        end
      end
    end
  end
endmodule // fec_busy_timer

// ===== fec_controller.v
// Flash erase, instruction cache profiling and block guard controller.
// Assumes an APB master on pclk, a flash array and cache behind simple strobes.
// What this block does
// R1: Page erase aliases act like primary erase.
// R2: Erase-everything bit one starts full erase.
// R3: User-area erase bit one erases config area.
// R4: Cache enable bit0, profiling bit8; clear invalidates.
// R5: Hit counter register reports cache hits.
// R6: Miss counter register reports cache miss_total.
// R7: Word program stays busy at least minimum.
// R8: Page erase stays busy at least minimum.
// R9: Full erase stays busy at least minimum.
// R10: Each protection bit guards one 4 kB block.
// R11: Four protection registers cover 128 blocks.
// R12: Protected write or erase blocked, hard fault.
// R13: Full erase with protection blocked, hard fault.
// R14: Reset clears all protection bits.
// R15: Protection bits set by one, sticky.
// R16: Debugger plus bypass disables protection check.
// R17: Software sets protection first after reset.
// R18: Erases start only in erase mode.
// R19: Full erase spares the factory info area.
// R20: Profiling counters count and saturate.
// R21: Processor stalled until erase finishes.
// R22: Hard fault is one-cycle pulse on rejection.
// R23: Bypass register is one bit at zero.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
`include "fec_consts.vh"
module fec_controller #(
  parameter AW = 32,
  parameter CW = 24,
  parameter WORD_CYCLES = (`FEC_T_WORD_NS + `FEC_CLK_NS - 1) / `FEC_CLK_NS,
  parameter PAGE_CYCLES = (`FEC_T_PAGE_US * 1000 + `FEC_CLK_NS - 1) / `FEC_CLK_NS,
  parameter ALL_CYCLES = (`FEC_T_ALL_US * 1000 + `FEC_CLK_NS - 1) / `FEC_CLK_NS
) (
  // Clock, reset and enable.
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Processor word writes into flash.
  input wire word_wr_req,
  input wire [AW-1:0] word_wr_addr,
  // Debugger presence pin, asynchronous.
  input wire debugger_attached,
  // Cache fetch results.
  input wire cache_hit,
  input wire cache_miss,
  // Flash array commands.
  output reg flash_program,
  output reg flash_page_erase,
  output reg [AW-1:0] flash_addr,
  output reg flash_erase_code,
  output reg flash_erase_user_area,
  output reg cache_invalidate,
  // Processor stall, ready flag and fault.
  output wire cpu_stall,
  output wire nvm_ready,
  output reg hard_fault
);
  // Configuration and state registers.
  reg [1:0] mode_ff;
  reg [31:0] page_ff;
  reg cache_on_ff;
  reg profiling_on_ff;
  reg [31:0] hit_ff;
  reg [31:0] miss_ff;
  reg [127:0] prot_ff;
  reg bypass_ff;
  reg dbg_meta_ff;
  reg dbg_sync_ff;
  reg start_ff;
  reg [CW-1:0] len_ff;
  wire busy;
  wire done;

  // APB decode; the slave answers with no wait states.
  assign pready = 1'b1;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire ofs_known = (paddr == `FEC_OFS_READY) || (paddr == `FEC_OFS_MODE) ||
    (paddr == `FEC_OFS_PAGE_A) || (paddr == `FEC_OFS_ERASE_ALL) ||
    (paddr == `FEC_OFS_PAGE_B) || (paddr == `FEC_OFS_USER_ERASE) ||
    (paddr == `FEC_OFS_CACHE_SETUP) || (paddr == `FEC_OFS_HIT_COUNT) ||
    (paddr == `FEC_OFS_MISS_COUNT) || (paddr == `FEC_OFS_PROT0) ||
    (paddr == `FEC_OFS_PROT1) || (paddr == `FEC_OFS_DBG_BYPASS) ||
    (paddr == `FEC_OFS_PROT2) || (paddr == `FEC_OFS_PROT3);
  // Unmapped addresses give an error and read as zero.
  assign pslverr = acc && !ofs_known;
  wire erase_mode = (mode_ff == `FEC_MODE_ERASE);
  wire write_mode = (mode_ff == `FEC_MODE_WRITE);

  // Protection check is off only with a debugger attached and bypass set.
  wire guard_on = !(dbg_sync_ff && bypass_ff); // R16
  // Block index from address bits above 4 kB; beyond 128 blocks nothing is guarded.
  wire [AW-1:0] blk_w = word_wr_addr >> `FEC_BLOCK_SHIFT; // R10
  wire [AW-1:0] blk_p = pwdata[AW-1:0] >> `FEC_BLOCK_SHIFT;
  wire hit_w = (blk_w < 128) && prot_ff[blk_w[6:0]]; // R10
  wire hit_p = (blk_p < 128) && prot_ff[blk_p[6:0]];
  wire any_prot = |prot_ff;

  // Command decode with write commands captured while idle.
  wire cmd_page = wr && ((paddr == `FEC_OFS_PAGE_A) || (paddr == `FEC_OFS_PAGE_B)); // R1
  wire cmd_all = wr && (paddr == `FEC_OFS_ERASE_ALL) && pwdata[`FEC_BIT_CMD]; // R2
  wire cmd_user = wr && (paddr == `FEC_OFS_USER_ERASE) && pwdata[`FEC_BIT_CMD]; // R3
  wire cmd_word = word_wr_req && write_mode && !busy && !start_ff;
  wire idle = !busy && !start_ff;
  wire bad_page = cmd_page && erase_mode && guard_on && hit_p; // R12
  wire bad_all = cmd_all && erase_mode && guard_on && any_prot; // R13
  wire bad_word = cmd_word && guard_on && hit_w; // R12
  wire go_page = cmd_page && erase_mode && idle && !bad_page; // R18
  wire go_all = cmd_all && erase_mode && idle && !bad_all; // R18
  wire go_user = cmd_user && erase_mode && idle; // R18
  wire go_word = cmd_word && !bad_word;

  // The operation timer stalls the processor while an operation runs.
  fec_busy_timer #(.CW(CW)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .start(start_ff),
    .cycles(len_ff),
    .busy(busy),
    .done(done)
  );
  assign cpu_stall = busy || start_ff; // R7 R21
  assign nvm_ready = !cpu_stall;

  // Debugger pin passes two flops before use.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_meta_ff <= 1'b0;
      dbg_sync_ff <= 1'b0;
    end else if (clk_en) begin
      dbg_meta_ff <= debugger_attached;
      dbg_sync_ff <= dbg_meta_ff;
    end
  end

  // Register writes, operation launch, counters and fault pulse.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= `FEC_MODE_READ;
      page_ff <= `FEC_RESET_WORD;
      cache_on_ff <= 1'b0;
      profiling_on_ff <= 1'b0;
      hit_ff <= `FEC_RESET_WORD;
      miss_ff <= `FEC_RESET_WORD;
      prot_ff <= {128{1'b0}}; // R14
      bypass_ff <= 1'b0;
      start_ff <= 1'b0;
      len_ff <= {CW{1'b0}};
      hard_fault <= 1'b0;
      flash_program <= 1'b0;
      flash_page_erase <= 1'b0;
      flash_erase_code <= 1'b0;
      flash_erase_user_area <= 1'b0;
      flash_addr <= {AW{1'b0}};
      cache_invalidate <= 1'b0;
    end else if (clk_en) begin
      start_ff <= 1'b0;
      flash_program <= 1'b0;
      flash_page_erase <= 1'b0;
      flash_erase_code <= 1'b0;
      flash_erase_user_area <= 1'b0;
      cache_invalidate <= 1'b0;
      // Fault is one cycle, in the cycle after the rejected access.
      hard_fault <= bad_page || bad_all || bad_word; // R22 R12 R13
      // Launch operations with their least busy times.
      if (go_word) begin
        start_ff <= 1'b1;
        len_ff <= WORD_CYCLES[CW-1:0]; // R7
        flash_program <= 1'b1;
        flash_addr <= word_wr_addr;
      end else if (go_page) begin
        start_ff <= 1'b1;
        len_ff <= PAGE_CYCLES[CW-1:0]; // R8
        flash_page_erase <= 1'b1;
        flash_addr <= pwdata[AW-1:0];
      end else if (go_all) begin
        start_ff <= 1'b1;
        len_ff <= ALL_CYCLES[CW-1:0]; // R9
        // Code and user area only; the factory area has no erase strobe.
        flash_erase_code <= 1'b1; // R19
        flash_erase_user_area <= 1'b1; // R19
      end else if (go_user) begin
        start_ff <= 1'b1;
        len_ff <= PAGE_CYCLES[CW-1:0];
        flash_erase_user_area <= 1'b1;
      end
      if (wr) begin
        case (paddr)
          `FEC_OFS_MODE: begin
            mode_ff <= pwdata[1:0];
            // Write or erase mode invalidates the cache.
            if (pwdata[1:0] != `FEC_MODE_READ) begin
              cache_invalidate <= 1'b1;
            end
          end
          `FEC_OFS_PAGE_A, `FEC_OFS_PAGE_B: begin
            page_ff <= pwdata; // R1
          end
          `FEC_OFS_CACHE_SETUP: begin
            cache_on_ff <= pwdata[`FEC_BIT_CACHE_ON];
            profiling_on_ff <= pwdata[`FEC_BIT_PROFILING_ON];
            if (!pwdata[`FEC_BIT_CACHE_ON]) begin
              cache_invalidate <= 1'b1; // R4
            end
          end
          `FEC_OFS_PROT0: begin
            prot_ff[31:0] <= prot_ff[31:0] | pwdata; // R15 R11
          end
          `FEC_OFS_PROT1: begin
            prot_ff[63:32] <= prot_ff[63:32] | pwdata; // R15 R11
          end
          `FEC_OFS_PROT2: begin
            prot_ff[95:64] <= prot_ff[95:64] | pwdata; // R15 R11
          end
          `FEC_OFS_PROT3: begin
            prot_ff[127:96] <= prot_ff[127:96] | pwdata; // R15 R11
          end
          `FEC_OFS_DBG_BYPASS: begin
            bypass_ff <= pwdata[`FEC_BIT_BYPASS]; // R23
          end
          default: begin
            page_ff <= page_ff;
          end
        endcase
      end
      // Counter writes win over counting in the same cycle.
      if (wr && (paddr == `FEC_OFS_HIT_COUNT)) begin
        hit_ff <= pwdata; // R5
      end else if (profiling_on_ff && cache_hit && (hit_ff != 32'hffffffff)) begin
        hit_ff <= hit_ff + 32'h00000001; // R20
      end
      if (wr && (paddr == `FEC_OFS_MISS_COUNT)) begin
        miss_ff <= pwdata; // R6
      end else if (profiling_on_ff && cache_miss && (miss_ff != 32'hffffffff)) begin
        miss_ff <= miss_ff + 32'h00000001; // R20
      end
    end
  end

  // Read mux; the erase-all and user-erase command registers read back as zero, the page aliases return page_ff.
  always @* begin
    prdata = `FEC_RESET_WORD;
    case (paddr)
      `FEC_OFS_READY: prdata = {31'h00000000, nvm_ready};
      `FEC_OFS_MODE: prdata = {30'h00000000, mode_ff};
      `FEC_OFS_PAGE_A, `FEC_OFS_PAGE_B: prdata = page_ff;
      `FEC_OFS_CACHE_SETUP: begin
        prdata[`FEC_BIT_CACHE_ON] = cache_on_ff;
        prdata[`FEC_BIT_PROFILING_ON] = profiling_on_ff;
      end
      `FEC_OFS_HIT_COUNT: prdata = hit_ff; // R5
      `FEC_OFS_MISS_COUNT: prdata = miss_ff; // R6
      `FEC_OFS_PROT0: prdata = prot_ff[31:0];
      `FEC_OFS_PROT1: prdata = prot_ff[63:32];
      `FEC_OFS_PROT2: prdata = prot_ff[95:64];
      `FEC_OFS_PROT3: prdata = prot_ff[127:96];
      `FEC_OFS_DBG_BYPASS: prdata = {31'h00000000, bypass_ff};
      default: prdata = `FEC_RESET_WORD;
    endcase
  end
endmodule // fec_controller

// ===== fec_controller_properties.sv
// Port checker for the flash erase, cache and block guard controller.
// Assumes it is bound onto fec_controller, whose port names it shares.
`timescale 1ns/1ns
module fec_checker #(
  parameter WORD_CYCLES = 5,
  parameter PAGE_CYCLES = 20,
  parameter ALL_CYCLES = 40
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // APB request.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // Flash commands and status.
  input wire [31:0] flash_addr,
  input wire flash_program,
  input wire flash_page_erase,
  input wire flash_erase_code,
  input wire flash_erase_user_area,
  input wire cpu_stall,
  input wire nvm_ready,
  input wire hard_fault
);
  // Busy cycles seen so far and the least busy length of the running job.
  logic [31:0] stall_cnt_ff;
  logic [31:0] need_ff;
  wire acc = psel && penable && pwrite;
  // The count restarts whenever the stall drops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_cnt_ff <= 32'h0;
      need_ff <= 32'h0;
    end else begin
      stall_cnt_ff <= cpu_stall ? stall_cnt_ff + 32'h1 : 32'h0;
      if (flash_program)
        need_ff <= WORD_CYCLES;
      else if (flash_erase_code)
        need_ff <= ALL_CYCLES;
      else if (flash_page_erase || flash_erase_user_area)
        need_ff <= PAGE_CYCLES;
      else if (!cpu_stall)
        need_ff <= 32'h0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A fault lasts exactly one cycle.
  sequence s_fault_once;
    hard_fault ##1 !hard_fault;
  endsequence
  AST_READY_INV: assert property (nvm_ready == !cpu_stall)
    else $error("ready flag is not the inverse of stall");
  AST_FAULT_PULSE: assert property (hard_fault |-> s_fault_once)
    else $error("fault is not a single pulse");
  AST_FAULT_NO_START: assert property (hard_fault |-> !(flash_program || flash_page_erase || flash_erase_code))
    else $error("rejected access still started");
  AST_ERASE_STALL: assert property ($rose(flash_erase_code) |-> cpu_stall ##1 cpu_stall)
    else $error("full erase without stall");
  AST_MIN_BUSY: assert property ($fell(cpu_stall) && need_ff != 0 |-> stall_cnt_ff >= need_ff)
    else $error("busy time too short");
  AST_PAGE_SRC: assert property (flash_page_erase |->
    $past(acc && (paddr == 12'h508 || paddr == 12'h510)) && flash_addr == $past(pwdata))
    else $error("page erase without alias write");
  AST_ALL_SRC: assert property (flash_erase_code |-> $past(acc && paddr == 12'h50c && pwdata[0]))
    else $error("full erase without command");
  AST_USER_SRC: assert property (flash_erase_user_area |->
    $past(acc && pwdata[0] && (paddr == 12'h514 || paddr == 12'h50c)))
    else $error("user area erase without command");
endmodule // fec_checker
bind fec_controller fec_checker #(.WORD_CYCLES(WORD_CYCLES), .PAGE_CYCLES(PAGE_CYCLES),
  .ALL_CYCLES(ALL_CYCLES)) u_chk (.*);

// ===== fec_cache_model.sv
// Cache stand-in that reports fetch hits and miss_total.
// Assumes the bench raises a request level for each cycle of results.
`timescale 1ns/1ns
module fec_cache_model (
  // Clock and requests.
  input wire pclk,
  input wire hit_req,
  input wire miss_req,
  // Fetch results.
  output logic cache_hit = 1'b0,
  output logic cache_miss = 1'b0
);
  // One result pulse for each requested cycle.
  always @(posedge pclk) begin
    cache_hit <= hit_req;
    cache_miss <= miss_req;
  end
endmodule // fec_cache_model

// ===== tb.sv
// Self-checking bench for the flash controller.
// Assumes the design, checker and cache model compile first.
`timescale 1ns/1ns
module tb;
  // Stimulus and observed signals.
  logic pclk = 0, presetn = 0, clk_en = 1;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, word_wr_addr = 0;
  logic word_wr_req = 0, debugger_attached = 0, hit_req = 0, miss_req = 0;
  logic [31:0] prdata, flash_addr, rd;
  logic pready, pslverr, cache_hit, cache_miss, flash_program, flash_page_erase;
  logic flash_erase_code, flash_erase_user_area, cache_invalidate, cpu_stall, nvm_ready, hard_fault, err;
  int n_errors = 0, comparisons = 0, cyc = 0;
  int n_flt = 0, n_pg = 0, n_all = 0, n_usr = 0, n_prg = 0, n_inv = 0;
  fec_controller #(.WORD_CYCLES(5), .PAGE_CYCLES(20), .ALL_CYCLES(40)) DUT (.*);
  fec_cache_model u_cache (.*);
  always #25 pclk = ~pclk;
  // Pulse tallies and the run limit.
  always @(posedge pclk) begin
    n_flt += hard_fault;
    n_pg += flash_page_erase;
    n_all += flash_erase_code;
    n_usr += flash_erase_user_area;
    n_prg += flash_program;
    n_inv += cache_invalidate;
    cyc++;
    if (cyc == 20000) begin
      $display("[FAIL] %0t timeout", $time);
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d = 0);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wait_idle();
    repeat (2) @(posedge pclk);
    while (nvm_ready !== 1'b1) @(posedge pclk);
  endtask
  task automatic t_regs();
    logic [11:0] ra[7] = '{12'h600, 12'h604, 12'h610, 12'h614, 12'h540, 12'h548, 12'h54c};
    foreach (ra[i]) begin
      apb(0, ra[i]);
      chk(rd, 0);
    end
    apb(0, 12'h60c);
    chk(err, 1);
  endtask
  task automatic t_erase();
    int s, p;
    s = n_all;
    p = n_pg;
    apb(1, 12'h504, 0);
    apb(1, 12'h50c, 1);
    apb(1, 12'h508, 32'h3000);
    wait_idle();
    chk(n_all + n_pg, s + p);
    apb(1, 12'h504, 2);
    apb(1, 12'h50c, 0);
    wait_idle();
    chk(n_all, s);
    apb(1, 12'h50c, 1);
    wait_idle();
    chk(n_all, s + 1);
    s = n_usr;
    apb(1, 12'h514, 1);
    wait_idle();
    chk(n_usr, s + 1);
    apb(1, 12'h508, 32'h5000);
    wait_idle();
    apb(1, 12'h510, 32'h6000);
    wait_idle();
    chk(n_pg, p + 2);
    chk(flash_addr, 32'h6000);
  endtask
  task automatic t_cache();
    int s;
    apb(1, 12'h540, 32'h101);
    hit_req <= 1;
    repeat (3) @(posedge pclk);
    hit_req <= 0;
    miss_req <= 1;
    repeat (2) @(posedge pclk);
    miss_req <= 0;
    repeat (3) @(posedge pclk);
    apb(0, 12'h548);
    chk(rd, 3);
    apb(0, 12'h54c);
    chk(rd, 2);
    apb(1, 12'h548, 32'hfffffffe);
    hit_req <= 1;
    repeat (3) @(posedge pclk);
    hit_req <= 0;
    repeat (2) @(posedge pclk);
    apb(0, 12'h548);
    chk(rd, 32'hffffffff);
    s = n_inv;
    apb(1, 12'h540, 0);
    @(posedge pclk);
    chk(n_inv, s + 1);
  endtask
  task automatic t_guard();
    int s, p;
    apb(1, 12'h600, 32'h8);
    apb(1, 12'h600, 0);
    apb(0, 12'h600);
    chk(rd, 32'h8);
    apb(1, 12'h614, 32'h80000000);
    s = n_flt;
    p = n_pg;
    apb(1, 12'h508, 32'h3000);
    apb(1, 12'h508, 32'h7f000);
    apb(1, 12'h50c, 1);
    @(posedge pclk);
    chk(n_flt, s + 3);
    apb(1, 12'h508, 32'h4000);
    wait_idle();
    chk(n_pg, p + 1);
    debugger_attached <= 1;
    apb(1, 12'h608, 1);
    apb(1, 12'h508, 32'h3000);
    wait_idle();
    chk(n_pg, p + 2);
    debugger_attached <= 0;
    apb(1, 12'h504, 1);
    s = n_prg;
    for (int a = 3; a <= 5; a += 2) begin
      word_wr_addr <= a << 12;
      word_wr_req <= 1;
      @(posedge pclk);
      word_wr_req <= 0;
      wait_idle();
    end
    chk(n_prg, s + 1);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h600);
    chk(rd, 0);
    apb(1, 12'h600, 32'h1);
    apb(0, 12'h600);
    chk(rd, 32'h1);
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence after a reset of 12 cycles.
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs();
    t_erase();
    t_cache();
    t_guard();
    summarize();
  end
endmodule // tb
